/* File: core/csi_timing_regs.svh */
/*
  Register offsets, field positions, reset values and timing figures of the
  D-PHY timing override bank. Offsets are register indices; the byte address
  on the bus is four times the index. Definitions only.
*/
`ifndef CSI_TIMING_REGS_SVH
`define CSI_TIMING_REGS_SVH

// register indices
`define IDX_P0_LPX        8'h48
`define IDX_P1_CLK_PREP   8'h60
`define IDX_P1_CLK_ZERO   8'h61
`define IDX_P1_CLK_TRAIL  8'h62
`define IDX_P1_CLK_POST   8'h63
`define IDX_P1_DATA_PREP  8'h64
`define IDX_LANE_RATE     8'h7F

// field positions
`define OVR_BIT           7
`define VAL_MSB           6
`define RATE0_LSB         0
`define RATE1_LSB         4

// automatic values at the 800 Mbps rate, which are also the reset values
`define RST_P0_LPX        7'h06
`define RST_P1_CLK_PREP   7'h05
`define RST_P1_CLK_ZERO   7'h1B
`define RST_P1_CLK_TRAIL  7'h0B
`define RST_P1_CLK_POST   7'h0A
`define RST_P1_DATA_PREP  7'h06

// lane rate scale in eighths of the 800 Mbps figure
`define MULT_400          5'h04
`define MULT_800          5'h08
`define MULT_1200         5'h0C
`define MULT_1500         5'h0F
`define MULT_1600         5'h10

`endif

/* File: core/csi_timing_pkg.sv */
/*
  Types shared by the D-PHY timing override bank.
  Assumes nothing of its surroundings.
*/
package csi_timing_pkg;

  // selectable CSI-2 lane rates
  typedef enum logic [2:0] {
    RATE_400  = 3'h0,
    RATE_800  = 3'h1,
    RATE_1200 = 3'h2,
    RATE_1500 = 3'h3,
    RATE_1600 = 3'h4
  } lane_rate_e;

  // one timing field
  typedef logic [6:0] timing_t;

  // slot of a timing register in the bank
  typedef logic [2:0] slot_t;

endpackage

/* File: core/csi_phy_timing_override_regs.sv */
/*
  D-PHY transmit timing override registers for two CSI-2 output ports,
  reached over a classic Wishbone slave with 32-bit data.
  Register map by index; the byte address is four times the index:
    0x48  port 0 lpx timing
    0x60  port 1 clock prepare timing
    0x61  port 1 clock zero timing
    0x62  port 1 clock trail timing
    0x63  port 1 clock post timing
    0x64  port 1 data prepare timing
    0x7F  lane rates, bits 2:0 for port 0 and bits 6:4 for port 1
  Lane rate codes: 0 400, 1 800, 2 1200, 3 1500, 4 1600 Mbps.
  Each timing register holds its override flag in bit 7 and its value in
  bits 6:0. Every request gets a one-cycle ack in the cycle after it is
  taken; unmapped reads return zero and unmapped writes are dropped.
  Assumes a single 200 MHz clock, a bus master on the same clock that
  drops its request after seeing ack, address bits above the bank held
  at zero for a hit, and transmitters that take the applied timing
  values as plain levels.
*/
// Operation
// - bit 7 picks the source: clear is automatic, set uses bits 6:0
// - with the flag clear the value field is read-only, reads automatic value
// - with the flag set the value field is writable and applied
// - automatic values follow the selected lane rate; resets match 800 Mbps
// - port 0 lpx register resets with flag clear, value 0x6
// - port 1 clock prepare register resets with flag clear, value 0x5
// - port 1 clock zero register resets with flag clear, value 0x1B
// - port 1 clock trail register resets with flag clear, value 0x0B
// - port 1 clock post register has bit 7 flag, value resets 0x0A
// - port 1 data prepare register resets with flag clear, value 0x6
`timescale 1ns/10ps
`include "csi_timing_regs.svh"

module csi_phy_timing_override_regs #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // wishbone slave
  input  wire logic                    wb_cyc,
  input  wire logic                    wb_stb,
  input  wire logic                    wb_we,
  input  wire logic [ADDR_W-1:0]       wb_adr,
  input  wire logic [3:0]              wb_sel,
  input  wire logic [31:0]             wb_dat_w,
  output logic      [31:0]             wb_dat_r,
  output logic                         wb_ack,
  // port 0 transmitter
  output csi_timing_pkg::lane_rate_e   port0_lane_rate,
  output csi_timing_pkg::timing_t      port0_lpx,
  // port 1 transmitter
  output csi_timing_pkg::lane_rate_e   port1_lane_rate,
  output csi_timing_pkg::timing_t      port1_clock_prepare,
  output csi_timing_pkg::timing_t      port1_clock_zero,
  output csi_timing_pkg::timing_t      port1_clock_trail,
  output csi_timing_pkg::timing_t      port1_clock_post,
  output csi_timing_pkg::timing_t      port1_data_prepare
);
  import csi_timing_pkg::*;

  localparam int NSLOT = 6;

  // the highest byte address must fit the bus address
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 9 and 32");
  end

  // every field must sit in byte 0, the only byte the write strobe looks at
  if (`RATE1_LSB + 3 > 8 || `OVR_BIT > 7) begin : g_bad_field
    $error("register fields must lie in byte 0");
  end

  // maps a register index to its slot; valid low when unmapped
  // bit 3 marks a hit so that slot zero stays distinct from a miss
  function automatic logic [3:0] decode(input logic [7:0] idx);
    case (idx)
      `IDX_P0_LPX:       decode = 4'h8;
      `IDX_P1_CLK_PREP:  decode = 4'h9;
      `IDX_P1_CLK_ZERO:  decode = 4'hA;
      `IDX_P1_CLK_TRAIL: decode = 4'hB;
      `IDX_P1_CLK_POST:  decode = 4'hC;
      `IDX_P1_DATA_PREP: decode = 4'hD;
      default:           decode = 4'h0;
    endcase
  endfunction

  // true when the address bits above the 1 KiB bank are all zero, so
  // a wider bus does not see the bank repeated through its space
  function automatic logic in_bank(input logic [ADDR_W-1:0] adr);
    in_bank = (adr >> 10) == {ADDR_W{1'b0}};
  endfunction

  // the 800 Mbps figure of each slot
  function automatic timing_t base_value(input slot_t s);
    case (s)
      3'h0:    base_value = `RST_P0_LPX;
      3'h1:    base_value = `RST_P1_CLK_PREP;
      3'h2:    base_value = `RST_P1_CLK_ZERO;
      3'h3:    base_value = `RST_P1_CLK_TRAIL;
      3'h4:    base_value = `RST_P1_CLK_POST;
      default: base_value = `RST_P1_DATA_PREP;
    endcase
  endfunction

  // automatic value: base scaled by rate, rounded up, held in 1..127
  function automatic timing_t auto_value(input slot_t s, input lane_rate_e r);
    logic [4:0]  mult;
    logic [11:0] prod;
    mult = `MULT_800;
    case (r)
      RATE_400:  mult = `MULT_400;
      RATE_800:  mult = `MULT_800;
      RATE_1200: mult = `MULT_1200;
      RATE_1500: mult = `MULT_1500;
      RATE_1600: mult = `MULT_1600;
      default:   mult = `MULT_800;
    endcase
    // widen before the product so the 1600 Mbps figures cannot wrap;
    // adding seven before dropping three bits rounds up
    prod = 12'(base_value(s)) * 12'(mult) + 12'h007;
    if (prod[11:10] != 2'h0) begin
      auto_value = 7'h7F;
    end else if (prod[9:3] == 7'h00) begin
      auto_value = 7'h01;
    end else begin
      auto_value = prod[9:3];
    end
  endfunction

  // reset release through two flip-flops; assertion is immediate, release
  // waits two edges so no flop leaves reset on a metastable level
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // override flags, stored values and their automatic and applied forms
  logic                ovr_q   [NSLOT];
  logic                ovr_d   [NSLOT];
  timing_t             val_q   [NSLOT];
  timing_t             val_d   [NSLOT];
  timing_t             auto_w  [NSLOT];
  timing_t             eff_w   [NSLOT];
  timing_t             app_q   [NSLOT];

  // lane rate of each port
  lane_rate_e          rate0_q;
  lane_rate_e          rate0_d;
  lane_rate_e          rate1_q;
  lane_rate_e          rate1_d;

  // bus answer
  logic                ack_q;
  logic                ack_d;
  logic [31:0]         rdat_q;
  logic [31:0]         rdat_d;

  // request decode
  logic                take;
  logic                bank_sel;
  logic                rate_sel;
  logic                wr_en;
  logic                rd_en;
  logic [7:0]          idx;
  logic [3:0]          hit;

  // a request is taken once, in the cycle before ack rises; a master that
  // keeps cyc and stb up after ack would be taken a second time
  assign take     = wb_cyc && wb_stb && !ack_q;
  assign idx      = 8'(wb_adr[ADDR_W-1:2]);
  assign bank_sel = in_bank(wb_adr);
  assign hit      = bank_sel ? decode(idx) : 4'h0;
  assign rate_sel = bank_sel && (idx == `IDX_LANE_RATE);

  // write strobe needs byte 0, where every field lives; reads ignore sel
  assign wr_en = take && wb_we && wb_sel[0];
  assign rd_en = take && !wb_we;

  // automatic and effective value per slot; slot 0 follows port 0 only and
  // the rest follow port 1, so neither port's rate or override moves the other
  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      if (s == 0) begin
        auto_w[s] = auto_value(slot_t'(s), rate0_q);
      end else begin
        auto_w[s] = auto_value(slot_t'(s), rate1_q);
      end
      eff_w[s] = ovr_q[s] ? val_q[s] : auto_w[s];
    end
  end

  // next register values on a bus write
  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      ovr_d[s] = ovr_q[s];
      val_d[s] = val_q[s];
    end
    rate0_d = rate0_q;
    rate1_d = rate1_q;
    if (wr_en) begin
      if (hit[3]) begin
        ovr_d[hit[2:0]] = wb_dat_w[`OVR_BIT];
        // the field only takes data while the flag stays or becomes set;
        // clearing the flag keeps the stored value hidden for later
        if (wb_dat_w[`OVR_BIT]) begin
          val_d[hit[2:0]] = wb_dat_w[`VAL_MSB:0];
        end
      end else if (rate_sel) begin
        // one write sets both ports; codes 5 to 7 are kept but scale
        // as 800 Mbps
        rate0_d = lane_rate_e'(wb_dat_w[`RATE0_LSB +: 3]);
        rate1_d = lane_rate_e'(wb_dat_w[`RATE1_LSB +: 3]);
      end
    end
  end

  // read data and acknowledge; every taken request is acked, mapped or not,
  // and unmapped indices read as zero; data stands only in the ack cycle,
  // zero otherwise, so the slave outputs can be ORed on a shared bus
  always_comb begin
    ack_d  = take;
    rdat_d = 32'h0000_0000;
    if (rd_en) begin
      if (hit[3]) begin
        // flag clear shows the automatic value, flag set the stored one
        rdat_d[`OVR_BIT]   = ovr_q[hit[2:0]];
        rdat_d[`VAL_MSB:0] = eff_w[hit[2:0]];
      end else if (rate_sel) begin
        rdat_d[`RATE0_LSB +: 3] = rate0_q;
        rdat_d[`RATE1_LSB +: 3] = rate1_q;
      end
    end
  end

  // register the bank; reset values equal the 800 Mbps automatic figures
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int s = 0; s < NSLOT; s++) begin
        ovr_q[s] <= 1'b0;
      end
      val_q[0] <= `RST_P0_LPX;
      val_q[1] <= `RST_P1_CLK_PREP;
      val_q[2] <= `RST_P1_CLK_ZERO;
      val_q[3] <= `RST_P1_CLK_TRAIL;
      val_q[4] <= `RST_P1_CLK_POST;
      val_q[5] <= `RST_P1_DATA_PREP;
      rate0_q  <= RATE_800;
      rate1_q  <= RATE_800;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h0000_0000;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        ovr_q[s] <= ovr_d[s];
        val_q[s] <= val_d[s];
      end
      rate0_q <= rate0_d;
      rate1_q <= rate1_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  // applied timing, registered so every output comes from a flip-flop
  // a change of flag, value or rate reaches the transmitter a cycle later
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      app_q[0] <= `RST_P0_LPX;
      app_q[1] <= `RST_P1_CLK_PREP;
      app_q[2] <= `RST_P1_CLK_ZERO;
      app_q[3] <= `RST_P1_CLK_TRAIL;
      app_q[4] <= `RST_P1_CLK_POST;
      app_q[5] <= `RST_P1_DATA_PREP;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        app_q[s] <= eff_w[s];
      end
    end
  end

  // outputs
  assign wb_dat_r            = rdat_q;
  assign wb_ack              = ack_q;
  assign port0_lane_rate     = rate0_q;
  assign port0_lpx           = app_q[0];
  assign port1_lane_rate     = rate1_q;
  assign port1_clock_prepare = app_q[1];
  assign port1_clock_zero    = app_q[2];
  assign port1_clock_trail   = app_q[3];
  assign port1_clock_post    = app_q[4];
  assign port1_data_prepare  = app_q[5];

endmodule

/* File: sim/csi_phy_timing_override_regs_props.sv */
/* checker: bus and override assertions on the timing bank ports
   assumes binding to the top module and one clock domain */
`timescale 1ns/10ps
module timing_regs_props #(parameter int ADDR_W = 10) (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  // wishbone
  input wire logic                    wb_cyc,
  input wire logic                    wb_stb,
  input wire logic                    wb_we,
  input wire logic [ADDR_W-1:0]       wb_adr,
  input wire logic [3:0]              wb_sel,
  input wire logic [31:0]             wb_dat_w,
  input wire logic [31:0]             wb_dat_r,
  input wire logic                    wb_ack,
  // port 0 applied lpx
  input wire csi_timing_pkg::timing_t port0_lpx
);
  import csi_timing_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // register index of the request
  logic [7:0] idx;
  assign idx = 8'(wb_adr[ADDR_W-1:2]);
  // request taken this edge
  sequence take;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence take_wr;
    take ##0 (wb_we && wb_sel[0]);
  endsequence
  AST_ACK_NEXT: assert property (take |=> wb_ack) else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack) else $error("ack longer than a cycle");
  AST_ACK_CAUSE: assert property (wb_ack |-> $past(wb_cyc && wb_stb)) else $error("stray ack");
  AST_DAT_IDLE: assert property (!wb_ack |-> wb_dat_r == 32'h0) else $error("data outside ack");
  AST_DAT_HIGH: assert property (wb_dat_r[31:8] == 24'h0) else $error("upper data set");
  AST_UNMAPPED: assert property (take ##0 (!wb_we && idx == 8'h10) |=> wb_dat_r == 32'h0)
    else $error("unmapped read not zero");
  AST_LPX_APPLY: assert property (take_wr ##0 (idx == 8'h48 && wb_dat_w[7])
    |-> ##2 port0_lpx == $past(wb_dat_w[6:0], 2)) else $error("lpx override not applied");
  AST_PORT_ISOLATE: assert property (take_wr ##0 (idx inside {[8'h60:8'h64]})
    |-> ##2 $stable(port0_lpx)) else $error("port 1 write moved port 0");
endmodule
bind csi_phy_timing_override_regs timing_regs_props #(.ADDR_W(ADDR_W)) u_props (
  .ref_clk(ref_clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
  .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
  .wb_ack(wb_ack), .port0_lpx(port0_lpx));

/* File: sim/csi_phy_timing_override_regs_tb_top.sv */
/* bench: table-driven register checks of the timing bank
   assumes the design package, header and module compiled first */
`timescale 1ns/10ps
module csi_phy_timing_override_regs_tb_top;
  import csi_timing_pkg::*;
  typedef struct {logic [7:0] wi, wd, ri, ex;} row_s;
  logic        ref_clk = 0, rstn = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
  logic [9:0]  wb_adr = 10'h000;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
  lane_rate_e  r0, r1;
  timing_t     lpx, cprep, czero, ctrail, cpost, dprep;
  int          n_errors = 0, checks_done = 0;
  // rows: write index, write data, read index, expected read byte
  row_s rows [17] = '{'{8'h10, 8'hFF, 8'h48, 8'h06}, '{8'h10, 8'hFF, 8'h60, 8'h05},
    '{8'h10, 8'hFF, 8'h61, 8'h1B}, '{8'h10, 8'hFF, 8'h62, 8'h0B}, '{8'h10, 8'hFF, 8'h63, 8'h0A},
    '{8'h10, 8'hFF, 8'h64, 8'h06}, '{8'h10, 8'hFF, 8'h10, 8'h00}, '{8'h48, 8'h05, 8'h48, 8'h06},
    '{8'h48, 8'hB3, 8'h48, 8'hB3}, '{8'h48, 8'h21, 8'h48, 8'h06}, '{8'h7F, 8'h41, 8'h61, 8'h36},
    '{8'h7F, 8'h01, 8'h61, 8'h0E}, '{8'h7F, 8'h21, 8'h61, 8'h29}, '{8'h7F, 8'h31, 8'h61, 8'h33},
    '{8'h7F, 8'h41, 8'h48, 8'h06}, '{8'h7F, 8'h41, 8'h7F, 8'h41}, '{8'h63, 8'hC4, 8'h63, 8'hC4}};
  csi_phy_timing_override_regs DUT (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .port0_lane_rate(r0), .port0_lpx(lpx),
    .port1_lane_rate(r1), .port1_clock_prepare(cprep), .port1_clock_zero(czero),
    .port1_clock_trail(ctrail), .port1_clock_post(cpost), .port1_data_prepare(dprep));
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic [7:0] idx, input logic we, input logic [3:0] sel,
                     input logic [7:0] d, output logic [31:0] rd);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_sel <= sel;
    wb_dat_w <= {24'h0, d};
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // verdict
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (rows[i]) begin
      bus(rows[i].wi, 1'b1, 4'h1, rows[i].wd, q);
      bus(rows[i].ri, 1'b0, 4'h0, 8'h00, q);
      check(q, {24'h0, rows[i].ex});
    end
    // applied values: port 1 at 1600, port 0 untouched at 800
    check(32'(lpx), 32'h06);
    check(32'(czero), 32'h36);
    check(32'(cprep), 32'h0A);
    check(32'(cpost), 32'h44);
    check(32'(ctrail), 32'h16);
    check(32'(dprep), 32'h0C);
    check(32'(r0), 32'h1);
    check(32'(r1), 32'h4);
    // write with byte 0 deselected is dropped
    bus(8'h48, 1'b1, 4'hE, 8'h99, q);
    bus(8'h48, 1'b0, 4'h0, 8'h00, q);
    check(q, 32'h06);
    // reset in mid-run restores override and rate
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    check(32'(cpost), 32'h0A);
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(8'h63, 1'b0, 4'h0, 8'h00, q);
    check(q, 32'h0A);
    check(32'(cpost), 32'h0A);
    check(32'(r1), 32'h1);
    check(32'(lpx), 32'h06);
    check(32'(cprep), 32'h05);
    check(32'(czero), 32'h1B);
    check(32'(ctrail), 32'h0B);
    check(32'(dprep), 32'h06);
    bus(8'h7F, 1'b0, 4'h0, 8'h00, q);
    check(q, 32'h11);
    tally_and_finish;
  end
endmodule
